/* File: core/buck_ctrl_pkg.sv */
// Constants shared by the step-down converter switching control logic
package buck_ctrl_pkg;

    // ****************************************************************
    // Clock and oscillator timing
    // ****************************************************************
    localparam int unsigned CLOCK_HZ = 250_000_000;
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned OSC_HZ = 2_400_000;
    // Rounded down, so the cycle is never longer than the nominal period
    localparam int unsigned OSC_PERIOD_CYCLES = CLOCK_HZ / OSC_HZ;
    localparam int unsigned SC_SLOW_DIV = 8;
    localparam int unsigned OSC_CNT_W = 10;

    // ****************************************************************
    // Non-overlap, reference wake-up and soft-start timing
    // ****************************************************************
    localparam int unsigned DEAD_NS = 8;
    localparam int unsigned DEAD_CYCLES = (DEAD_NS * CLOCK_MHZ + 999) / 1000;
    localparam int unsigned DEAD_CNT_W = 4;
    localparam int unsigned REF_WAKE_US = 20;
    localparam int unsigned REF_WAKE_CYCLES = REF_WAKE_US * CLOCK_MHZ;
    localparam int unsigned SOFT_START_US = 1200;
    localparam int unsigned SOFT_START_CYCLES = SOFT_START_US * CLOCK_MHZ;
    localparam int unsigned TIMER_W = 19;

    // ****************************************************************
    // Pulse-skip entry
    // ****************************************************************
    localparam int unsigned ZC_CNT_W = 5;
    localparam logic [ZC_CNT_W-1:0] ZC_ENTRY_COUNT = 5'h10;

    // ****************************************************************
    // Analog status inputs, positions in the synchronised vector
    // ****************************************************************
    localparam int unsigned NUM_SENSE = 12;
    localparam int unsigned S_ENABLE = 0;
    localparam int unsigned S_UNDERVOLTAGE_LOCKOUT = 1;
    localparam int unsigned S_OVER_TEMP = 2;
    localparam int unsigned S_CURRENT_TRIP = 3;
    localparam int unsigned S_ZERO_CROSS = 4;
    localparam int unsigned S_LIGHT_LOAD = 5;
    localparam int unsigned S_OVERCURRENT = 6;
    localparam int unsigned S_SHORT_CIRCUIT = 7;
    localparam int unsigned S_OUT_HIGH = 8;
    localparam int unsigned S_OUT_NOMINAL = 9;
    localparam int unsigned S_OUT_LOW = 10;
    localparam int unsigned S_DROPOUT = 11;

endpackage

/* File: core/buck_switch_control.sv */
// Switching control logic of the step-down converter
`timescale 1ns/1ps
`default_nettype none

module buck_switch_control
    import buck_ctrl_pkg::*;
#(
    parameter int unsigned REF_WAKE_LEN = REF_WAKE_CYCLES,
    parameter int unsigned SOFT_START_LEN = SOFT_START_CYCLES,
    parameter int unsigned DEAD_LEN = DEAD_CYCLES,
    parameter int unsigned OSC_PERIOD = OSC_PERIOD_CYCLES,
    parameter int unsigned OSC_SLOW_DIV = SC_SLOW_DIV
) (
    input wire logic i_clock,               // 250 MHz system clock
    input wire logic i_rst,                 // Synchronous reset, active high
    input wire logic i_enable,              // Enable pin level
    input wire logic i_undervoltage_lockout, // Input supply below lockout
    input wire logic i_over_temp,           // Thermal shutdown comparator
    input wire logic i_current_trip,        // Peak current loop comparator
    input wire logic i_zero_cross,          // Switch node current crossed zero
    input wire logic i_light_load_trip,     // Current at light-load level
    input wire logic i_overcurrent_detector, // High side current at limit
    input wire logic i_short_circuit_detector, // Feedback below threshold
    input wire logic i_out_above_high,      // Output 1.5% above nominal
    input wire logic i_out_below_nominal,   // Output at or below nominal
    input wire logic i_out_below_low,       // Output over 1.5% below nominal
    input wire logic i_dropout,             // Input too low to regulate
    output logic o_high_side_on,            // High-side switch gate
    output logic o_low_side_on,             // Low-side switch gate
    output logic o_discharge_on,            // Output discharge path
    output logic o_reference_on,            // Internal reference powered
    output logic o_soft_start_active,       // Soft-start ramp running
    output logic o_pulse_skip_mode,         // Pulse-skip mode active
    output logic o_regulating               // Soft-start complete
);

    // ****************************************************************
    // Types and declarations
    // ****************************************************************
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_REF_WAKE,
        PWR_SOFT_START,
        PWR_RUN
    } power_state_e;

    typedef enum logic [2:0] {
        SW_OFF,
        SW_DEAD_HS,
        SW_HS,
        SW_DEAD_LS,
        SW_LS
    } switch_state_e;

    power_state_e pwr_reg;
    power_state_e pwr_next;
    switch_state_e sw_reg;
    switch_state_e sw_next;

    logic [NUM_SENSE-1:0] sense_raw;
    logic [NUM_SENSE-1:0] sense;
    logic cycle_start;

    logic [TIMER_W-1:0] timer_reg;
    logic [DEAD_CNT_W-1:0] dead_reg;
    logic [ZC_CNT_W-1:0] zc_count_reg;
    logic zc_seen_reg;
    logic skip_reg;
    logic skip_idle_reg;

    // ****************************************************************
    // Input synchronisation and oscillator
    // ****************************************************************
    assign sense_raw[S_ENABLE] = i_enable;
    assign sense_raw[S_UNDERVOLTAGE_LOCKOUT] = i_undervoltage_lockout;
    assign sense_raw[S_OVER_TEMP] = i_over_temp;
    assign sense_raw[S_CURRENT_TRIP] = i_current_trip;
    assign sense_raw[S_ZERO_CROSS] = i_zero_cross;
    assign sense_raw[S_LIGHT_LOAD] = i_light_load_trip;
    assign sense_raw[S_OVERCURRENT] = i_overcurrent_detector;
    assign sense_raw[S_SHORT_CIRCUIT] = i_short_circuit_detector;
    assign sense_raw[S_OUT_HIGH] = i_out_above_high;
    assign sense_raw[S_OUT_NOMINAL] = i_out_below_nominal;
    assign sense_raw[S_OUT_LOW] = i_out_below_low;
    assign sense_raw[S_DROPOUT] = i_dropout;

    sense_sync #(
        .WIDTH(NUM_SENSE)
    ) u_sense_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(sense_raw),
        .o_sync(sense)
    );

    switch_oscillator #(
        .PERIOD(OSC_PERIOD),
        .SLOW_DIV(OSC_SLOW_DIV)
    ) u_osc (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_slow(sense[S_SHORT_CIRCUIT]),
        .o_cycle_start(cycle_start)
    );

    // ****************************************************************
    // Power sequencing
    // ****************************************************************
    wire enable_ok = sense[S_ENABLE] && !sense[S_UNDERVOLTAGE_LOCKOUT];
    // Over-temperature drops to off, so recovery repeats the full start
    wire power_ok = enable_ok && !sense[S_OVER_TEMP];
    wire timer_done = (timer_reg == '0);
    wire switching = (pwr_reg == PWR_SOFT_START) || (pwr_reg == PWR_RUN);

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_OFF: begin
                if (power_ok) begin
                    pwr_next = PWR_REF_WAKE;
                end
            end
            PWR_REF_WAKE: begin
                if (timer_done) begin
                    pwr_next = PWR_SOFT_START;
                end
            end
            PWR_SOFT_START: begin
                if (timer_done) begin
                    pwr_next = PWR_RUN;
                end
            end
            PWR_RUN: begin
                pwr_next = PWR_RUN;
            end
        endcase
        if (!power_ok) begin
            pwr_next = PWR_OFF;
        end
    end

    wire load_ref_timer = (pwr_reg == PWR_OFF) && (pwr_next == PWR_REF_WAKE);
    wire load_ss_timer = (pwr_reg == PWR_REF_WAKE) && (pwr_next == PWR_SOFT_START);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pwr_reg <= PWR_OFF;
            timer_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
            if (load_ref_timer) begin
                timer_reg <= TIMER_W'(REF_WAKE_LEN - 1);
            end else if (load_ss_timer) begin
                timer_reg <= TIMER_W'(SOFT_START_LEN - 1);
            end else if (!timer_done) begin
                timer_reg <= timer_reg - 1'b1;
            end
        end
    end

    // ****************************************************************
    // Zero-cross counting and pulse-skip mode
    // ****************************************************************
    wire zc_now = sense[S_ZERO_CROSS];
    wire zc_in_cycle = zc_seen_reg || zc_now;
    wire zc_full = (zc_count_reg == ZC_ENTRY_COUNT - 1'b1);
    wire skip_enter = switching && !skip_reg && cycle_start && zc_in_cycle && zc_full;
    wire skip_leave = skip_reg && sense[S_OUT_LOW];

    always_ff @(posedge i_clock) begin
        if (i_rst || !switching || skip_reg) begin
            zc_seen_reg <= 1'b0;
            zc_count_reg <= '0;
        end else if (cycle_start) begin
            zc_seen_reg <= 1'b0;
            if (!zc_in_cycle) begin
                zc_count_reg <= '0;
            end else if (!zc_full) begin
                zc_count_reg <= zc_count_reg + 1'b1;
            end
        end else begin
            zc_seen_reg <= zc_in_cycle;
        end
    end

    // Leaving wins over a new idle request so the loop regains control
    always_ff @(posedge i_clock) begin
        if (i_rst || !switching) begin
            skip_reg <= 1'b0;
            skip_idle_reg <= 1'b0;
        end else if (skip_leave) begin
            skip_reg <= 1'b0;
            skip_idle_reg <= 1'b0;
        end else if (skip_enter) begin
            skip_reg <= 1'b1;
        end else if (skip_reg && sense[S_OUT_HIGH]) begin
            skip_idle_reg <= 1'b1;
        end else if (skip_idle_reg && sense[S_OUT_NOMINAL]) begin
            skip_idle_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Switch sequencing
    // ****************************************************************
    wire dead_done = (dead_reg == '0);
    wire dropout_hold = !skip_reg && sense[S_DROPOUT];
    // Loop trip ignored in dropout; the overcurrent limit never is
    wire pwm_end = sense[S_CURRENT_TRIP] && !dropout_hold;
    wire skip_end = sense[S_LIGHT_LOAD] || sense[S_OUT_HIGH];
    wire hs_end = sense[S_OVERCURRENT] || (skip_reg ? skip_end : pwm_end);
    wire pulse_allowed = !(skip_reg && (skip_idle_reg || sense[S_OUT_HIGH]));

    always_comb begin
        sw_next = sw_reg;
        unique case (sw_reg)
            SW_OFF: begin
                if (cycle_start && pulse_allowed) begin
                    sw_next = SW_DEAD_HS;
                end
            end
            SW_DEAD_HS: begin
                if (dead_done) begin
                    sw_next = SW_HS;
                end
            end
            SW_HS: begin
                if (hs_end) begin
                    sw_next = skip_reg ? SW_OFF : SW_DEAD_LS;
                    if (skip_reg && !sense[S_OUT_HIGH]) begin
                        sw_next = SW_DEAD_LS;
                    end
                end
            end
            SW_DEAD_LS: begin
                if (dead_done) begin
                    sw_next = SW_LS;
                end
            end
            SW_LS: begin
                if (cycle_start && pulse_allowed) begin
                    sw_next = SW_DEAD_HS;
                end else if (skip_reg && (zc_now || cycle_start)) begin
                    sw_next = SW_OFF;
                end
            end
            default: begin
                sw_next = SW_OFF;
            end
        endcase
        if (!switching) begin
            sw_next = SW_OFF;
        end
    end

    wire load_dead = (sw_next == SW_DEAD_HS || sw_next == SW_DEAD_LS) && (sw_next != sw_reg);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sw_reg <= SW_OFF;
            dead_reg <= '0;
        end else begin
            sw_reg <= sw_next;
            if (load_dead) begin
                dead_reg <= DEAD_CNT_W'(DEAD_LEN - 1);
            end else if (!dead_done) begin
                dead_reg <= dead_reg - 1'b1;
            end
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Gates follow the next state so they change in step with sw_reg;
    // only one of the two can decode true for any state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_high_side_on <= 1'b0;
            o_low_side_on <= 1'b0;
            o_discharge_on <= 1'b0;
            o_reference_on <= 1'b0;
            o_soft_start_active <= 1'b0;
            o_pulse_skip_mode <= 1'b0;
            o_regulating <= 1'b0;
        end else begin
            o_high_side_on <= (sw_next == SW_HS);
            o_low_side_on <= (sw_next == SW_LS);
            o_discharge_on <= !sense[S_ENABLE];
            o_reference_on <= (pwr_next != PWR_OFF);
            o_soft_start_active <= (pwr_next == PWR_SOFT_START);
            o_pulse_skip_mode <= skip_reg;
            o_regulating <= (pwr_next == PWR_RUN);
        end
    end

endmodule
`default_nettype wire

/* File: core/sense_sync.sv */
// Two flip-flop synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ps
`default_nettype none

module sense_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clock,               // System clock
    input wire logic i_rst,                 // Synchronous reset, active high
    input wire logic [WIDTH-1:0] i_async,   // Raw asynchronous levels
    output logic [WIDTH-1:0] o_sync         // Levels after two flops
);

    logic [WIDTH-1:0] meta_reg;

    // The first stage feeds only the second stage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule
`default_nettype wire

/* File: core/switch_oscillator.sv */
// Switching oscillator: one start pulse per switching cycle, slow on demand
`timescale 1ns/1ps
`default_nettype none

module switch_oscillator
    import buck_ctrl_pkg::*;
#(
    parameter int unsigned PERIOD = OSC_PERIOD_CYCLES,
    parameter int unsigned SLOW_DIV = SC_SLOW_DIV
) (
    input wire logic i_clock,       // System clock
    input wire logic i_rst,         // Synchronous reset, active high
    input wire logic i_slow,        // Run at the reduced frequency
    output logic o_cycle_start      // One-cycle pulse at each cycle start
);

    localparam int unsigned SLOW_W = 8;

    logic [OSC_CNT_W-1:0] count_reg;
    logic [SLOW_W-1:0] slow_reg;
    logic period_end;
    logic slow_end;

    assign period_end = (count_reg == OSC_CNT_W'(PERIOD - 1));
    assign slow_end = !i_slow || (slow_reg == SLOW_W'(SLOW_DIV - 1));

    // The slow rate only stretches the spacing of start pulses, so a pulse
    // in progress is never cut short when the short circuit appears
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= '0;
            slow_reg <= '0;
            o_cycle_start <= 1'b0;
        end else begin
            count_reg <= period_end ? '0 : count_reg + 1'b1;
            if (period_end) begin
                slow_reg <= slow_end ? '0 : slow_reg + 1'b1;
            end
            o_cycle_start <= period_end && slow_end;
        end
    end

endmodule
`default_nettype wire

/* File: dv/buck_ctrl_monitor.sv */
// Concurrent checks on the switching control ports
`timescale 1ns/1ps
`default_nettype none

module buck_ctrl_monitor (
    input wire logic i_clock,                  // System clock
    input wire logic i_rst,                    // Synchronous reset
    input wire logic i_enable,                 // Enable
    input wire logic i_undervoltage_lockout,   // Lockout
    input wire logic i_over_temp,              // Thermal
    input wire logic i_current_trip,           // Peak trip
    input wire logic i_zero_cross,             // Zero cross
    input wire logic i_light_load_trip,        // Light trip
    input wire logic i_overcurrent_detector,   // Current limit
    input wire logic i_short_circuit_detector, // Short
    input wire logic i_out_above_high,         // Output high
    input wire logic i_out_below_nominal,      // Output nominal
    input wire logic i_out_below_low,          // Output low
    input wire logic i_dropout,                // Dropout
    input wire logic o_high_side_on,           // High gate
    input wire logic o_low_side_on,            // Low gate
    input wire logic o_discharge_on,           // Discharge
    input wire logic o_reference_on,           // Reference
    input wire logic o_soft_start_active,      // Soft-start
    input wire logic o_pulse_skip_mode,        // Skip mode
    input wire logic o_regulating              // Running
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_no_overlap;
        !(o_high_side_on && o_low_side_on);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
    property p_gap_low_high;
        $fell(o_low_side_on) |-> !o_high_side_on [*2];
    endproperty
    a_gap_low_high: assert property (p_gap_low_high) else $error("no gap before high");
    property p_gap_high_low;
        $fell(o_high_side_on) |-> !o_low_side_on [*2];
    endproperty
    a_gap_high_low: assert property (p_gap_high_low) else $error("no gap before low");
    property p_disable;
        !i_enable [*4] |=> o_discharge_on && !o_high_side_on && !o_low_side_on;
    endproperty
    a_disable: assert property (p_disable) else $error("disable not honoured");
    property p_lockout;
        i_undervoltage_lockout [*4] |=> !o_reference_on && !o_high_side_on && !o_low_side_on;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout not honoured");
    property p_ref_first;
        $rose(o_reference_on) |-> !o_soft_start_active [*8];
    endproperty
    a_ref_first: assert property (p_ref_first) else $error("soft-start too early");
    property p_overcurrent;
        i_overcurrent_detector && o_high_side_on |-> ##[1:4] !o_high_side_on;
    endproperty
    a_overcurrent: assert property (p_overcurrent) else $error("limit ignored");
    property p_current_trip;
        i_current_trip && o_high_side_on && !i_dropout && !o_pulse_skip_mode
            |-> ##[1:5] !o_high_side_on;
    endproperty
    a_current_trip: assert property (p_current_trip) else $error("trip ignored");
    property p_above_high;
        o_pulse_skip_mode && i_out_above_high && o_high_side_on |-> ##[1:4] !o_high_side_on;
    endproperty
    a_above_high: assert property (p_above_high) else $error("high output ignored");
    property p_below_low;
        i_out_below_low [*4] |=> !o_pulse_skip_mode;
    endproperty
    a_below_low: assert property (p_below_low) else $error("skip mode kept");
endmodule

bind buck_switch_control buck_ctrl_monitor u_monitor (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable),
    .i_undervoltage_lockout(i_undervoltage_lockout), .i_over_temp(i_over_temp),
    .i_current_trip(i_current_trip), .i_zero_cross(i_zero_cross),
    .i_light_load_trip(i_light_load_trip), .i_overcurrent_detector(i_overcurrent_detector),
    .i_short_circuit_detector(i_short_circuit_detector), .i_out_above_high(i_out_above_high),
    .i_out_below_nominal(i_out_below_nominal), .i_out_below_low(i_out_below_low),
    .i_dropout(i_dropout), .o_high_side_on(o_high_side_on), .o_low_side_on(o_low_side_on),
    .o_discharge_on(o_discharge_on), .o_reference_on(o_reference_on),
    .o_soft_start_active(o_soft_start_active), .o_pulse_skip_mode(o_pulse_skip_mode),
    .o_regulating(o_regulating)
);
`default_nettype wire

/* File: dv/load_model.sv */
// Behavioural inductor and load: comparator levels from gate timing
`timescale 1ns/1ps
`default_nettype none

module load_model (
    input wire logic i_clock,            // System clock
    input wire logic i_high_side_on,     // High-side gate
    input wire logic i_low_side_on,      // Low-side gate
    input wire logic i_light,            // Light load: current returns to zero
    input wire logic [7:0] i_trip_len,   // High-side cycles until peak trip
    output logic o_current_trip,         // Peak current comparator
    output logic o_zero_cross,           // Zero-cross comparator
    output logic o_light_load_trip       // Light-load comparator
);
    logic [7:0] hs_cnt_reg = 8'h00;
    logic [7:0] ls_cnt_reg = 8'h00;
    logic [7:0] hs_cnt_next;
    logic [7:0] ls_cnt_next;

    // Counters saturate so a long full-duty stretch cannot wrap back under the trip
    assign hs_cnt_next = !i_high_side_on ? 8'h00 : hs_cnt_reg + {7'h00, hs_cnt_reg != 8'hff};
    assign ls_cnt_next = !i_low_side_on ? 8'h00 : ls_cnt_reg + {7'h00, ls_cnt_reg != 8'hff};

    always_ff @(posedge i_clock) begin
        hs_cnt_reg <= hs_cnt_next;
        ls_cnt_reg <= ls_cnt_next;
    end

    assign o_current_trip = hs_cnt_reg >= i_trip_len;
    assign o_light_load_trip = i_light && (hs_cnt_reg >= 8'h04);
    assign o_zero_cross = i_light && (ls_cnt_reg >= 8'h06);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the switching control logic
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int PER = 40;
    localparam int SLOW = 8;
    localparam int HS = 0, REF = 3, SS = 4, SKP = 5, RUN = 6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0, uv = 1'b0, ot = 1'b0, oc = 1'b0, sc = 1'b0, dr = 1'b0;
    logic ah = 1'b0, bn = 1'b0, bl = 1'b0, light = 1'b0;
    logic [7:0] trip_len = 8'h0a;
    wire logic ct, zc, lt, hs, ls, dis, refon, ss, skp, run;
    wire logic [6:0] outv = {run, skp, ss, refon, dis, ls, hs};
    int mismatches = 0;
    int n_tests = 0;

    always #2 clk = ~clk;

    buck_switch_control #(.REF_WAKE_LEN(20), .SOFT_START_LEN(50), .DEAD_LEN(2),
        .OSC_PERIOD(PER), .OSC_SLOW_DIV(SLOW)) dut (
        .i_clock(clk), .i_rst(rst), .i_enable(en), .i_undervoltage_lockout(uv),
        .i_over_temp(ot), .i_current_trip(ct), .i_zero_cross(zc), .i_light_load_trip(lt),
        .i_overcurrent_detector(oc), .i_short_circuit_detector(sc), .i_out_above_high(ah),
        .i_out_below_nominal(bn), .i_out_below_low(bl), .i_dropout(dr),
        .o_high_side_on(hs), .o_low_side_on(ls), .o_discharge_on(dis), .o_reference_on(refon),
        .o_soft_start_active(ss), .o_pulse_skip_mode(skp), .o_regulating(run));

    load_model load (.i_clock(clk), .i_high_side_on(hs), .i_low_side_on(ls), .i_light(light),
        .i_trip_len(trip_len), .o_current_trip(ct), .o_zero_cross(zc), .o_light_load_trip(lt));

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        n_tests++;
        if (c !== 1'b1) begin
            $display("Error at %0t ns: %s", $time, m);
            mismatches++;
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wait_out(input int idx, input logic v, input int lim);
        int n;
        n = 0;
        while (outv[idx] !== v && n < lim) begin
            step(1);
            n++;
        end
        if (outv[idx] !== v) begin
            chk(1'b0, "wait on output ran out");
            wrap_up();
        end
    endtask

    // Cycles until the high side next turns on
    task automatic next_rise(output int n);
        n = 0;
        while (hs !== 1'b0 && n < 400) begin
            step(1);
            n++;
        end
        while (hs !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        if (hs !== 1'b1) begin
            chk(1'b0, "no high-side pulse");
            wrap_up();
        end
    endtask

    task automatic count_on(input int idx, input int len, output int k);
        k = 0;
        repeat (len) begin
            step(1);
            if (outv[idx] === 1'b1)
                k++;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_start;
        wait_out(REF, 1'b1, 6);
        chk(ss === 1'b0, "soft-start before reference");
        wait_out(SS, 1'b1, 25);
        wait_out(RUN, 1'b1, 60);
    endtask

    task automatic t_pwm;
        int n;
        next_rise(n);
        next_rise(n);
        chk(n == PER, "pulse-width period wrong");
        step(PER - 6);
        chk(ls === 1'b1 && hs === 1'b0, "low side not held");
    endtask

    task automatic t_overcurrent;
        int n;
        trip_len = 8'h1e;
        next_rise(n);
        step(2);
        oc = 1'b1;
        wait_out(HS, 1'b0, 5);
        oc = 1'b0;
        trip_len = 8'h0a;
    endtask

    task automatic t_skip;
        int n;
        int k;
        light = 1'b1;
        repeat (10) next_rise(n);
        light = 1'b0;
        repeat (2) next_rise(n);
        light = 1'b1;
        repeat (14) next_rise(n);
        chk(skp === 1'b0, "counter not cleared");
        k = 0;
        while (skp !== 1'b1 && k < 4) begin
            next_rise(n);
            k++;
        end
        chk(skp === 1'b1, "skip mode not entered");
        next_rise(n);
        next_rise(n);
        chk(n == PER, "skip pulse not aligned");
        count_on(HS, 12, k);
        chk(k < 10, "light-load trip ignored");
        // Raise the high threshold mid-pulse so the immediate cut-off is exercised
        next_rise(n);
        ah = 1'b1;
        step(4);
        count_on(HS, 2 * PER, k);
        chk(k == 0 && ls === 1'b0, "switching not stopped");
        ah = 1'b0;
        bn = 1'b1;
        next_rise(n);
        chk(n <= PER + 6, "pulses not resumed");
        bn = 1'b0;
        bl = 1'b1;
        wait_out(SKP, 1'b0, 6);
        bl = 1'b0;
        light = 1'b0;
    endtask

    task automatic t_short;
        int n;
        sc = 1'b1;
        repeat (3) next_rise(n);
        chk(n == PER * SLOW, "short period wrong");
        sc = 1'b0;
        next_rise(n);
    endtask

    task automatic t_dropout;
        int k;
        dr = 1'b1;
        step(PER + 8);
        count_on(HS, 2 * PER, k);
        chk(k == 2 * PER, "high side not held on");
        dr = 1'b0;
        step(8);
    endtask

    task automatic t_fault(input int sel);
        if (sel == 0)
            uv = 1'b1;
        else
            ot = 1'b1;
        step(4);
        chk(refon === 1'b0 && hs === 1'b0 && ls === 1'b0, "not shut down");
        // Discharge follows enable alone, so a fault leaves it off
        chk(dis === 1'b0, "discharge on fault");
        uv = 1'b0;
        ot = 1'b0;
        t_start();
    endtask

    task automatic t_disable;
        en = 1'b0;
        step(4);
        chk(hs === 1'b0 && ls === 1'b0 && dis === 1'b1, "disable wrong");
    endtask

    initial begin
        step(20);
        rst = 1'b0;
        step(2);
        chk(dis === 1'b1 && hs === 1'b0 && refon === 1'b0, "state after reset");
        en = 1'b1;
        t_start();
        chk(dis === 1'b0, "discharge while enabled");
        t_pwm();
        t_overcurrent();
        t_skip();
        t_short();
        t_dropout();
        t_fault(0);
        t_fault(1);
        t_disable();
        wrap_up();
    end
endmodule
`default_nettype wire
